// ### common/ignition_defines.svh
// Constants for the burner ignition sequencer: offsets, fields, resets, timing
`ifndef IGNITION_DEFINES_SVH
`define IGNITION_DEFINES_SVH

// ------------------------------------------------------------
// Clock and timer tick
// ------------------------------------------------------------
`define CLK_HZ 50000000
`define TICK_MS 100
`define TICK_CYCLES ((`CLK_HZ / 1000) * `TICK_MS)
`define TICKS_PER_SEC (1000 / `TICK_MS)

// ------------------------------------------------------------
// Fixed state and supervision times, in seconds
// ------------------------------------------------------------
`define PRE_IGNIT_SEC 2
`define IGNIT_SEC 3
`define PROVING_SEC 2
`define SAFETY_SEC 5
`define LATE_FLAME_SEC 10
`define FLAME_EARLY_SEC 1
`define FAN_SUPERVISE_SEC 60

// ------------------------------------------------------------
// Fan limits in RPM
// ------------------------------------------------------------
`define FAN_TOL_RPM 16'd300
`define FAN_HIGH_RPM 16'd4200

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define ADDR_CTRL 8'h00
`define ADDR_CFG_TIME 8'h04
`define ADDR_CFG_LIMIT 8'h08
`define ADDR_FAN 8'h0c
`define ADDR_STATUS 8'h10
`define ADDR_IRQ_STAT 8'h14
`define ADDR_IRQ_MASK 8'h18

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CTRL_DEMAND_BIT 0
`define CTRL_RESET_BIT 14
`define IRQ_LOCKOUT_BIT 0
`define IRQ_BURN_BIT 1
`define IRQ_FLAME_LOSS_BIT 2
`define IRQ_IGN_FAIL_BIT 3

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CFG_TIME_RST 32'h000a_0014
`define CFG_LIMIT_RST 32'h0033_001e
`define FAN_RST 32'h0bb8_0000

// ------------------------------------------------------------
// Lockout error codes
// ------------------------------------------------------------
`define ERR_NONE 8'h00
`define ERR_LATE_FLAME 8'h14
`define ERR_FLAME_EARLY 8'h01
`define ERR_IGN_TRIALS 8'h02
`define ERR_FLAME_TRIALS 8'h03
`define ERR_FAN 8'h04

`endif

// ### common/ignition_pkg.sv
// Types shared by the burner ignition sequencer
package ignition_pkg;

  // Gray codes along the normal cycle
  typedef enum logic [3:0] {
    ST_STANDBY    = 4'h0,
    ST_PREPURGE0  = 4'h1,
    ST_PREPURGE1  = 4'h3,
    ST_PREIGNIT   = 4'h2,
    ST_IGNIT      = 4'h6,
    ST_PROVING    = 4'h7,
    ST_BURN       = 4'h5,
    ST_POSTBURN   = 4'h4,
    ST_POSTPURGE0 = 4'hc,
    ST_POSTPURGE1 = 4'hd,
    ST_LOCKOUT    = 4'hf
  } seq_state_t;

endpackage : ignition_pkg

// ### rtl/tick_gen.sv
// Fixed-rate tick pulse derived from the system clock
`timescale 1ns/100ps
`default_nettype none

module tick_gen #(
  parameter int unsigned TICK_CYCLES = 5000000
) (
  input wire logic hclk,
  input wire logic hresetn,
  output logic tick
);

  initial begin
    if (TICK_CYCLES < 2) $error("tick_gen: TICK_CYCLES must be at least 2");
  end

  logic [31:0] cnt_q;

  // ------------------------------------------------------------
  // Free-running divider
  // ------------------------------------------------------------
  assign tick = (cnt_q == 32'(TICK_CYCLES - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt_q <= 32'h0;
    else if (tick) cnt_q <= 32'h0;
    else cnt_q <= cnt_q + 32'h1;
  end

endmodule : tick_gen

`default_nettype wire

// ### rtl/down_timer.sv
// Loadable down-counter in tick units
`timescale 1ns/100ps
`default_nettype none

module down_timer #(
  parameter int unsigned W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic tick,
  output logic done,
  output logic [W-1:0] count
);

  initial begin
    if (W < 2 || W > 32) $error("down_timer: W out of range");
  end

  logic [W-1:0] count_q;

  assign count = count_q;
  assign done = (count_q == '0);

  // ------------------------------------------------------------
  // Load wins over counting; stops at zero
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) count_q <= '0;
    else if (load) count_q <= load_val;
    else if (tick && !done) count_q <= count_q - W'(1);
  end

endmodule : down_timer

`default_nettype wire

// ### rtl/burner_ignition_sequencer.sv
// Burner ignition sequencer with AHB-Lite registers and safety supervision
// Notes on behaviour
// R1: Demand enters zero-length purge setup, fan off, then pre-purge at ignition speed.
// R2: Pre-ignition runs igniter two seconds at ignition speed before gas.
// R3: Safety period is ignition plus flame proving, five seconds in total.
// R4: Ignition lasts three seconds: gas open, igniter on, ignition fan speed.
// R5: Flame proving lasts two seconds: igniter off, gas open, ignition speed.
// R6: Proven flame enters burn: gas open, fan modulates, no time limit.
// R7: Post-burn is zero length: gas closes, ignition speed, starts post-purge.
// R8: First post-purge waits for flame to vanish; after ten seconds lock error 20.
// R9: Second post-purge holds ignition speed for the post-purge duration.
// R10: Standby stops fan and keeps gas closed; pump overrun may continue.
// R11: Heating pump keeps running for the overrun duration after demand ends.
// R12: Flame for one second during pre-ignition causes lockout.
// R13: No flame after safety period: post-purge and retry; trials exhausted lock.
// R14: Flame loss in burn restarts burner, limited by flame trial count.
// R15: Fan must stay within 300 RPM of target; violation for 60 s locks.
// R16: In burn with both speeds above 4200 RPM the deviation check is skipped.
// R17: Reset request honoured only in lockout, then clears itself.
// R18: Lockout latches with gas closed and igniter off until reset accepted.
// R19: Purge and pump overrun durations counted by tick timer, loaded from configuration registers; other times are fixed.
`include "ignition_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module burner_ignition_sequencer
  import ignition_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
  parameter int unsigned TW = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic flame_detected,
  input wire logic [15:0] fan_speed_actual,
  output logic fan_run,
  output logic [15:0] fan_speed_target,
  output logic igniter_on,
  output logic gas_valve_open,
  output logic heating_pump_on,
  output logic lockout,
  output logic irq
);

  localparam logic [TW-1:0] TPS = TW'(`TICKS_PER_SEC);
  localparam logic [TW-1:0] PRE_IGNIT_T = TW'(`PRE_IGNIT_SEC * `TICKS_PER_SEC);
  localparam logic [TW-1:0] IGNIT_T = TW'(`IGNIT_SEC * `TICKS_PER_SEC);
  localparam logic [TW-1:0] PROVING_T = TW'(`PROVING_SEC * `TICKS_PER_SEC);
  localparam logic [TW-1:0] LATE_T = TW'(`LATE_FLAME_SEC * `TICKS_PER_SEC);
  localparam logic [TW-1:0] EARLY_T = TW'(`FLAME_EARLY_SEC * `TICKS_PER_SEC);
  localparam logic [TW-1:0] FAN_T = TW'(`FAN_SUPERVISE_SEC * `TICKS_PER_SEC);

  // Safety period must be exactly ignition plus proving
  initial begin
    if (`IGNIT_SEC + `PROVING_SEC != `SAFETY_SEC) $error("safety period mismatch"); // R3
    if (TW < 16 || TW > 24) $error("TW must be 16 to 24");
    if (TICK_CYCLES < 2) $error("TICK_CYCLES too small");
  end

  // ------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------
  seq_state_t state_q, state_d;
  logic [31:0] ctrl_q, cfg_time_q, cfg_limit_q, fan_cfg_q;
  logic [3:0] irq_stat_q, irq_mask_q;
  logic [7:0] err_q;
  logic [3:0] ign_trials_q, flame_restarts_q;
  logic [7:0] dph_addr_q;
  logic dph_wr_q;
  logic [31:0] rdata_q;
  logic gas_q, ign_q, fan_run_q, pump_q;
  logic [15:0] fan_tgt_q;
  logic demand_q;

  // ------------------------------------------------------------
  // AHB-Lite decode
  // ------------------------------------------------------------
  wire aph_valid = hsel && hready && htrans[1];
  wire wr_ctrl = dph_wr_q && (dph_addr_q == `ADDR_CTRL);
  wire wr_time = dph_wr_q && (dph_addr_q == `ADDR_CFG_TIME);
  wire wr_limit = dph_wr_q && (dph_addr_q == `ADDR_CFG_LIMIT);
  wire wr_fan = dph_wr_q && (dph_addr_q == `ADDR_FAN);
  wire wr_istat = dph_wr_q && (dph_addr_q == `ADDR_IRQ_STAT);
  wire wr_imask = dph_wr_q && (dph_addr_q == `ADDR_IRQ_MASK);

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address phase captured; zero-wait data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_addr_q <= 8'h00;
      dph_wr_q <= 1'b0;
    end else begin
      dph_addr_q <= haddr;
      dph_wr_q <= aph_valid && hwrite;
    end
  end

  // ------------------------------------------------------------
  // Configuration fields
  // ------------------------------------------------------------
  wire [11:0] pre_purge_duration = cfg_time_q[11:0];
  wire [11:0] post_purge_duration = cfg_time_q[27:16];
  wire [11:0] heating_pump_overrun_duration = cfg_limit_q[11:0];
  wire [3:0] max_ignit_trials = cfg_limit_q[19:16];
  wire [3:0] max_flame_trials = cfg_limit_q[23:20];
  wire [15:0] fan_modulate_rpm = fan_cfg_q[15:0];
  wire [15:0] fan_ignit_rpm = fan_cfg_q[31:16];
  wire [TW-1:0] pre_purge_t = TW'(pre_purge_duration) * TPS; // R19
  wire [TW-1:0] post_purge_t = TW'(post_purge_duration) * TPS; // R19
  wire [TW-1:0] pump_t = TW'(heating_pump_overrun_duration) * TPS; // R19
  wire demand = ctrl_q[`CTRL_DEMAND_BIT];
  wire reset_req = ctrl_q[`CTRL_RESET_BIT];

  // ------------------------------------------------------------
  // Timers on a common tick
  // ------------------------------------------------------------
  logic tick, st_done, early_done, fan_done, pump_done, st_load;
  logic [TW-1:0] st_load_val;

  tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick)
  );

  down_timer #(.W(TW)) u_state_tmr (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(st_load),
    .load_val(st_load_val),
    .tick(tick),
    .done(st_done),
    .count()
  );

  // Early flame must persist one second before it locks
  wire early_arm = (state_q == ST_PREIGNIT) && flame_detected;
  down_timer #(.W(TW)) u_early_tmr (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(!early_arm),
    .load_val(EARLY_T),
    .tick(tick),
    .done(early_done),
    .count()
  );

  // Fan deviation check, skipped at high speed while burning
  wire [15:0] fan_dev = (fan_speed_actual > fan_tgt_q) ? fan_speed_actual - fan_tgt_q
                                                       : fan_tgt_q - fan_speed_actual;
  wire fan_high = (state_q == ST_BURN) && (fan_speed_actual > `FAN_HIGH_RPM)
                  && (fan_tgt_q > `FAN_HIGH_RPM); // R16
  wire fan_bad = (fan_dev > `FAN_TOL_RPM) && !fan_high && (state_q != ST_LOCKOUT); // R15
  down_timer #(.W(TW)) u_fan_tmr (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(!fan_bad),
    .load_val(FAN_T),
    .tick(tick),
    .done(fan_done),
    .count()
  );

  // Pump overrun reloads while demand stands
  down_timer #(.W(TW)) u_pump_tmr (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(demand),
    .load_val(pump_t),
    .tick(tick),
    .done(pump_done),
    .count()
  );

  // ------------------------------------------------------------
  // Lockout causes; lock_code priority is late flame, early flame, ignition trials, flame trials, fan
  // ------------------------------------------------------------
  wire early_lock = early_arm && early_done; // R12
  wire fan_lock = fan_bad && fan_done; // R15
  wire late_lock = (state_q == ST_POSTPURGE0) && st_done && flame_detected; // R8
  wire ign_fail = (state_q == ST_PROVING) && st_done && !flame_detected;
  wire ign_lock = ign_fail && (ign_trials_q + 4'h1 >= max_ignit_trials); // R13
  wire flame_loss = (state_q == ST_BURN) && !flame_detected;
  wire flame_lock = flame_loss && (flame_restarts_q >= max_flame_trials); // R14
  wire any_lock = early_lock || fan_lock || late_lock || ign_lock || flame_lock;
  wire reset_accept = reset_req && (state_q == ST_LOCKOUT); // R17

  logic [7:0] lock_code;
  assign lock_code = late_lock ? `ERR_LATE_FLAME :
                     early_lock ? `ERR_FLAME_EARLY :
                     ign_lock ? `ERR_IGN_TRIALS :
                     flame_lock ? `ERR_FLAME_TRIALS : `ERR_FAN;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_STANDBY: begin
        if (demand) state_d = ST_PREPURGE0; // R1
      end
      ST_PREPURGE0: state_d = ST_PREPURGE1; // R1
      ST_PREPURGE1: begin
        if (!demand) state_d = ST_STANDBY;
        else if (st_done) state_d = ST_PREIGNIT; // R1
      end
      ST_PREIGNIT: begin
        if (!demand) state_d = ST_STANDBY;
        else if (st_done) state_d = ST_IGNIT; // R2
      end
      ST_IGNIT: begin
        if (!demand) state_d = ST_POSTBURN;
        else if (st_done) state_d = ST_PROVING; // R3
      end
      ST_PROVING: begin
        if (st_done && flame_detected) state_d = ST_BURN; // R6
        else if (st_done || !demand) state_d = ST_POSTBURN; // R13
      end
      ST_BURN: begin
        if (flame_loss || !demand) state_d = ST_POSTBURN; // R14
      end
      ST_POSTBURN: state_d = ST_POSTPURGE0; // R7
      ST_POSTPURGE0: begin
        if (!flame_detected) state_d = ST_POSTPURGE1; // R8
      end
      ST_POSTPURGE1: begin
        if (st_done) state_d = demand ? ST_PREPURGE0 : ST_STANDBY; // R9
      end
      ST_LOCKOUT: begin
        if (reset_accept) state_d = ST_STANDBY; // R18
      end
      default: state_d = ST_STANDBY;
    endcase
    if (any_lock && state_q != ST_LOCKOUT) state_d = ST_LOCKOUT; // R18
  end

  // State timer reloads on every state entry
  assign st_load = (state_d != state_q);
  always_comb begin
    case (state_d)
      ST_PREPURGE1: st_load_val = pre_purge_t; // R1
      ST_PREIGNIT: st_load_val = PRE_IGNIT_T; // R2
      ST_IGNIT: st_load_val = IGNIT_T; // R4
      ST_PROVING: st_load_val = PROVING_T; // R5
      ST_POSTPURGE0: st_load_val = LATE_T; // R8
      ST_POSTPURGE1: st_load_val = post_purge_t; // R9
      default: st_load_val = '0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) state_q <= ST_STANDBY;
    else state_q <= state_d;
  end

  // ------------------------------------------------------------
  // Trial counters and error code
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ign_trials_q <= 4'h0;
      flame_restarts_q <= 4'h0;
      err_q <= `ERR_NONE;
    end else if (reset_accept) begin
      ign_trials_q <= 4'h0;
      flame_restarts_q <= 4'h0;
      err_q <= `ERR_NONE;
    end else begin
      if (state_q == ST_PROVING && state_d == ST_BURN) ign_trials_q <= 4'h0;
      else if (ign_fail) ign_trials_q <= ign_trials_q + 4'h1; // R13
      if (flame_loss && demand) flame_restarts_q <= flame_restarts_q + 4'h1; // R14
      else if (state_q == ST_STANDBY) flame_restarts_q <= 4'h0;
      if (any_lock && state_q != ST_LOCKOUT) err_q <= lock_code;
    end
  end

  // ------------------------------------------------------------
  // Actuator outputs per state
  // ------------------------------------------------------------
  wire gas_d = (state_d == ST_IGNIT) || (state_d == ST_PROVING) || (state_d == ST_BURN);
  wire ign_d = (state_d == ST_PREIGNIT) || (state_d == ST_IGNIT); // R2
  wire fan_off_d = (state_d == ST_STANDBY) || (state_d == ST_PREPURGE0)
                   || (state_d == ST_LOCKOUT); // R10
  wire [15:0] fan_tgt_d = fan_off_d ? 16'h0000 :
                          (state_d == ST_BURN) ? fan_modulate_rpm : fan_ignit_rpm; // R6

  // Outputs follow the next state so they change with the state itself
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gas_q <= 1'b0;
      ign_q <= 1'b0;
      fan_run_q <= 1'b0;
      fan_tgt_q <= 16'h0000;
      pump_q <= 1'b0;
      demand_q <= 1'b0;
    end else begin
      gas_q <= gas_d; // R4
      ign_q <= ign_d; // R5
      fan_run_q <= !fan_off_d; // R7
      fan_tgt_q <= fan_tgt_d;
      pump_q <= demand || !pump_done; // R11
      demand_q <= demand;
    end
  end

  assign gas_valve_open = gas_q;
  assign igniter_on = ign_q;
  assign fan_run = fan_run_q;
  assign fan_speed_target = fan_tgt_q;
  assign heating_pump_on = pump_q;
  assign lockout = (state_q == ST_LOCKOUT);

  // ------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------
  // Reset request bit self-clears one cycle after it is written
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= 32'h0;
      cfg_time_q <= `CFG_TIME_RST;
      cfg_limit_q <= `CFG_LIMIT_RST;
      fan_cfg_q <= `FAN_RST;
      irq_mask_q <= 4'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= 32'h0;
        ctrl_q[`CTRL_DEMAND_BIT] <= hwdata[`CTRL_DEMAND_BIT];
        ctrl_q[`CTRL_RESET_BIT] <= hwdata[`CTRL_RESET_BIT];
      end else begin
        ctrl_q[`CTRL_RESET_BIT] <= 1'b0; // R17
      end
      if (wr_time) cfg_time_q <= hwdata & 32'h0fff_0fff;
      if (wr_limit) cfg_limit_q <= hwdata & 32'h00ff_0fff;
      if (wr_fan) fan_cfg_q <= hwdata;
      if (wr_imask) irq_mask_q <= hwdata[3:0];
    end
  end

  // Sticky events; a new event wins over a write-one clear
  wire [3:0] irq_ev = {ign_fail, flame_loss && (state_d == ST_POSTBURN || any_lock),
                       (state_q == ST_PROVING) && (state_d == ST_BURN),
                       any_lock && (state_q != ST_LOCKOUT)};
  wire [3:0] irq_clr = wr_istat ? hwdata[3:0] : 4'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) irq_stat_q <= 4'h0;
    else irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // Status word and read mux; unmapped reads give zero
  wire [31:0] status_w = {8'h00, flame_restarts_q, ign_trials_q, err_q,
                          1'b0, demand_q, pump_q, lockout, 4'(state_q)};
  wire aph_read = aph_valid && !hwrite;
  wire [31:0] rdata_d = !aph_read ? 32'h0 :
                        (haddr == `ADDR_CTRL) ? ctrl_q :
                        (haddr == `ADDR_CFG_TIME) ? cfg_time_q :
                        (haddr == `ADDR_CFG_LIMIT) ? cfg_limit_q :
                        (haddr == `ADDR_FAN) ? fan_cfg_q :
                        (haddr == `ADDR_STATUS) ? status_w :
                        (haddr == `ADDR_IRQ_STAT) ? {28'h0, irq_stat_q} :
                        (haddr == `ADDR_IRQ_MASK) ? {28'h0, irq_mask_q} : 32'h0;

  // Taken at the address phase so read data comes from a flop for the whole data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rdata_q <= 32'h0;
    else rdata_q <= rdata_d;
  end

  assign hrdata = rdata_q;

  // hsize is accepted as word only; other sizes are not decoded separately
  wire unused_ok = &{1'b0, hsize};

endmodule : burner_ignition_sequencer

`default_nettype wire

// ### dv/burner_ignition_properties.sv
// Port-level assertions for the burner ignition sequencer
`timescale 1ns/100ps
`default_nettype none
module burner_ignition_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic fan_run,
  input wire logic igniter_on,
  input wire logic gas_valve_open,
  input wire logic lockout
);
  // ----
  // Single domain, so one clocking and disable
  // ----
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  lock_safe_a: assert property (lockout |-> !gas_valve_open && !igniter_on && !fan_run)
    else $error("actuator active in lockout");
  purge_first_a: assert property ($rose(fan_run) |-> !igniter_on [*8])
    else $error("igniter without pre-purge");
  spark_before_gas_a: assert property ($rose(igniter_on) |-> !gas_valve_open && fan_run)
    else $error("gas open at spark start");
  gas_with_spark_a: assert property ($rose(gas_valve_open) |-> igniter_on [*8])
    else $error("igniter off during ignition");
  proving_gas_a: assert property ($fell(igniter_on) && gas_valve_open |-> gas_valve_open [*8])
    else $error("gas closed early in proving");
  gas_needs_fan_a: assert property (gas_valve_open || igniter_on |-> fan_run)
    else $error("gas or igniter without fan");
  postburn_fan_a: assert property ($fell(gas_valve_open) && !lockout |-> fan_run)
    else $error("fan stopped at post-burn");
endmodule : burner_ignition_properties
`default_nettype wire

// ### dv/burner_plant.sv
// Far-side model: flame sensor and fan tacho
`timescale 1ns/100ps
`default_nettype none
module burner_plant (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [2:0] mode,
  input wire logic fan_run,
  input wire logic [15:0] fan_speed_target,
  input wire logic gas_valve_open,
  output logic flame_detected,
  output logic [15:0] fan_speed_actual
);
  logic lit_q;
  logic [3:0] wob_q;
  // Flame follows the valve a cycle late; mode 3 never dies out
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lit_q <= 1'b0;
      wob_q <= 4'h0;
    end else begin
      lit_q <= gas_valve_open || (mode == 3'd3 && lit_q);
      wob_q <= wob_q + 4'h1;
    end
  end
  // Mode 1 never lights, mode 2 is a stray flame, mode 5 blows out off ignition speed
  wire blow_out = (mode == 3'd5) && (fan_speed_target != 16'd3000);
  assign flame_detected = (mode == 3'd2) || (mode != 3'd1 && lit_q && !blow_out);
  // Small wobble keeps the tacho honest; mode 4 stalls, mode 6 reads 400 high above 4200
  wire [15:0] fan_skew = (mode == 3'd6 && fan_speed_target > 16'd4200) ? 16'd400 : 16'd0;
  assign fan_speed_actual = (fan_run && mode != 3'd4) ?
                            fan_speed_target + {12'h000, wob_q} + fan_skew : 16'h0;
endmodule : burner_plant
`default_nettype wire

// ### dv/burner_ignition_sequencer_bench.sv
// Self-checking bench for the burner ignition sequencer
`timescale 1ns/100ps
`default_nettype none
module burner_ignition_sequencer_bench;
  import ignition_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0] mode = 3'd0;
  logic [31:0] hrdata, rd_q, r, tgt;
  logic hreadyout, hresp, flame_detected, fan_run, igniter_on, gas_valve_open;
  logic heating_pump_on, lockout, irq;
  logic [15:0] fan_speed_actual, fan_speed_target;
  int n_tests = 0;
  int bad_count = 0;
  time t0;
  burner_ignition_sequencer #(.TICK_CYCLES(4)) DUT (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .flame_detected(flame_detected), .fan_speed_actual(fan_speed_actual),
    .fan_run(fan_run), .fan_speed_target(fan_speed_target), .igniter_on(igniter_on),
    .gas_valve_open(gas_valve_open), .heating_pump_on(heating_pump_on),
    .lockout(lockout), .irq(irq));
  burner_plant plant (.hclk(hclk), .hresetn(hresetn), .mode(mode), .fan_run(fan_run),
    .fan_speed_target(fan_speed_target), .gas_valve_open(gas_valve_open),
    .flame_detected(flame_detected), .fan_speed_actual(fan_speed_actual));
  initial forever #10 hclk = ~hclk;
  // Read data as it stood at the edge closing the data phase
  always @(posedge hclk) rd_q <= hrdata;
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // Lockout code expected for each far-side fault mode
  function automatic logic [7:0] lock_err(input int m);
    return m == 1 ? 8'h02 : m == 2 ? 8'h01 : m == 3 ? 8'd20 : m == 4 ? 8'h04 : 8'h03;
  endfunction : lock_err
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  task automatic await_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      bad_count++;
      end_of_test;
    end
  endtask : await_ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    await_ready;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    await_ready;
    #1 r = rd_q;
  endtask : bus
  task automatic wait_st(input logic [3:0] s);
    int n;
    n = 0;
    do begin
      bus(1'b0, 8'h10, 32'h0);
      n++;
    end while (r[3:0] !== s && n < 900);
    chk({28'h0, r[3:0]}, {28'h0, s});
    if (r[3:0] !== s) end_of_test;
  endtask : wait_st
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 8'h04, 32'h0);
    chk(r, {4'h0, 12'd10, 4'h0, 12'd20});
    bus(1'b0, 8'h08, 32'h0);
    chk(r, {8'h0, 4'd3, 4'd3, 4'h0, 12'd30});
    bus(1'b0, 8'h1c, 32'h0);
    chk(r, 32'h0);
    tgt = 32'd1000 + (xs(32'h79b426a3) % 32'd2000);
    bus(1'b1, 8'h04, 32'h0001_0001);
    bus(1'b1, 8'h08, 32'h0033_0004);
    bus(1'b1, 8'h0c, {16'd3000, tgt[15:0]});
    bus(1'b1, 8'h18, 32'h0);
    // Reset request outside lockout is dropped and self-clears
    bus(1'b1, 8'h00, 32'h0000_4000);
    bus(1'b0, 8'h00, 32'h0);
    chk(r, 32'h0);
    // Normal cycle with the flame lighting on the valve
    bus(1'b1, 8'h00, 32'h1);
    wait_st(ST_PREPURGE1);
    chk({fan_run, fan_speed_target}, {1'b1, 16'd3000});
    wait_st(ST_PREIGNIT);
    chk({gas_valve_open, igniter_on, fan_run}, 3'b011);
    wait_st(ST_IGNIT);
    t0 = $time;
    chk({gas_valve_open, igniter_on, fan_run}, 3'b111);
    wait_st(ST_PROVING);
    chk({gas_valve_open, igniter_on, fan_run}, 3'b101);
    wait_st(ST_BURN);
    chk(($time - t0) / 20 inside {[190:206]}, 1);
    chk({gas_valve_open, fan_speed_target}, {1'b1, tgt[15:0]});
    // Burn event is held back by the mask, then cleared by one
    chk(irq, 1'b0);
    bus(1'b1, 8'h18, 32'hf);
    @(posedge hclk);
    #1 chk(irq, 1'b1);
    bus(1'b1, 8'h14, 32'h2);
    @(posedge hclk);
    #1 chk(irq, 1'b0);
    bus(1'b1, 8'h00, 32'h0);
    wait_st(ST_STANDBY);
    chk({heating_pump_on, fan_run, gas_valve_open}, 3'b100);
    repeat (200) @(posedge hclk);
    #1 chk(heating_pump_on, 1'b0);
    // High-speed burn with a 400 RPM offset must outlast fan supervision
    mode <= 3'd6;
    bus(1'b1, 8'h0c, {16'd3000, 16'd4201 + tgt[15:0]});
    bus(1'b1, 8'h00, 32'h1);
    wait_st(ST_BURN);
    repeat (2600) @(posedge hclk);
    bus(1'b0, 8'h10, 32'h0);
    chk(r[4:0], 5'h05);
    bus(1'b1, 8'h00, 32'h0);
    wait_st(ST_STANDBY);
    // Each far-side fault ends in its own latched lockout
    for (int m = 1; m <= 5; m++) begin
      mode <= 3'(m);
      bus(1'b1, 8'h00, 32'h1);
      if (m == 3) begin
        wait_st(ST_BURN);
        bus(1'b1, 8'h00, 32'h0);
      end
      wait_st(ST_LOCKOUT);
      chk(r[15:8], lock_err(m));
      bus(1'b0, 8'h14, 32'h0);
      chk({irq, r[0]}, 2'b11);
      bus(1'b1, 8'h14, 32'hf);
      mode <= 3'd0;
      bus(1'b1, 8'h00, 32'h1);
      repeat (100) @(posedge hclk);
      wait_st(ST_LOCKOUT);
      bus(1'b1, 8'h00, 32'h4000);
      wait_st(ST_STANDBY);
    end
    end_of_test;
  end
endmodule : burner_ignition_sequencer_bench
bind burner_ignition_sequencer burner_ignition_properties props (.hclk(hclk),
  .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .fan_run(fan_run),
  .igniter_on(igniter_on), .gas_valve_open(gas_valve_open), .lockout(lockout));
`default_nettype wire
